// ==== bench/urx_checker.sv ====
/* Port assertions for the serial receive block.
   Assumes one clock, core_clk, and synchronous active-high rst. */
`timescale 1ns/1ps
module urx_checker #(
  parameter RECOV = 16
) (
  // Clock and reset
  input wire        core_clk,
  input wire        rst,
  // Register bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Line, power and gates
  input wire        serial_line_pin,
  input wire        mod_clk_on,
  input wire        cpu_sleep,
  input wire        tx_empty,
  input wire        tx_idle,
  input wire        global_irq_gate,
  input wire        port_irq_gate,
  // Requests
  input wire        irq_n,
  input wire        wake_evt
);
  localparam int LO = 1;
  localparam int HI = RECOV + 30;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Bus handshake
  property p_ready_after_setup; psel && !penable |=> pready; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready missing after setup");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready held too long");
  property p_slverr_with_ready; pslverr |-> pready; endproperty
  a_slverr_with_ready: assert property (p_slverr_with_ready) else $error("pslverr without pready");
  property p_slverr_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_slverr_zero: assert property (p_slverr_zero) else $error("refused read returned data");
  property p_prdata_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("prdata moved without a read");
  property p_reset_quiet; $fell(rst) |-> irq_n && !wake_evt && !pready; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  // Wake-up behaviour
  property p_wake_pulse; wake_evt |=> !wake_evt; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  property p_wake_clkoff; wake_evt |-> !$past(mod_clk_on); endproperty
  a_wake_clkoff: assert property (p_wake_clkoff) else $error("wake with clock running");
  property p_wake_defer; wake_evt |-> irq_n [*2]; endproperty
  a_wake_defer: assert property (p_wake_defer) else $error("wake request not deferred");
  property p_wake_irq; wake_evt && global_irq_gate && port_irq_gate |-> ##[LO:HI] !irq_n; endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("gated wake gave no request");
  // Main scenarios reached
  c_wake: cover property (wake_evt && global_irq_gate);
  c_refused: cover property (pslverr);
  c_irq: cover property (!irq_n);
endmodule
bind urx_top urx_checker #(.RECOV(RECOV)) u_urx_checker (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_line_pin(serial_line_pin), .mod_clk_on(mod_clk_on), .cpu_sleep(cpu_sleep),
  .tx_empty(tx_empty), .tx_idle(tx_idle), .global_irq_gate(global_irq_gate), .port_irq_gate(port_irq_gate),
  .irq_n(irq_n), .wake_evt(wake_evt));

// ==== bench/urx_line_model.sv ====
/* Remote serial transmitter model driving the line pin.
   Assumes BIT core_clk cycles per bit and an idle-high line. */
`timescale 1ns/1ps
module urx_line_model #(
  parameter BIT = 16
) (
  // Clock and line
  input  wire  core_clk,
  output logic line
);
  // Line rests high between frames
  initial line = 1'b1;
  // Send start, data LSB first, optional parity, stops, then one idle bit
  task automatic send(input logic [8:0] w, input logic nine, input logic pon, input logic [1:0] pt,
                      input logic s2, input logic bp, input logic bs);
    logic q[$];
    logic p;
    p = pt[1] ? ~pt[0] : (^w[7:0] ^ (nine & w[8]) ^ pt[0]);
    q.push_back(1'b0);
    for (int i = 0; i < (nine ? 9 : 8); i++) q.push_back(w[i]);
    if (pon) q.push_back(p ^ bp);
    q.push_back(1'b1);
    if (s2) q.push_back(1'b1);
    if (bs) q[q.size() - 1] = 1'b0;
    q.push_back(1'b1);
    foreach (q[i]) repeat (BIT) @(posedge core_clk) line <= q[i];
  endtask
endmodule

// ==== bench/urx_top_tb.sv ====
/* Self-checking bench for the serial receive block.
   Assumes the line model drives the pin and the checker is bound in. */
`timescale 1ns/1ps
`include "urx_regs.vh"
module urx_top_tb;
  logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic        pready, pslverr, line, err, irq_n, wake_evt;
  logic        mod_clk_on = 1'b1, cpu_sleep = 1'b0, tx_empty = 1'b0, tx_idle = 1'b0, glb = 1'b1, prt = 1'b1;
  int          errors = 0, comparisons = 0, cyc = 0, irqs = 0, wakes = 0, n, k;
  logic [8:0]  aw [4] = '{9'h07F, 9'h080, 9'h001, 9'h100};
  logic [31:0] a1 [4] = '{32'h3, 32'h3, 32'h3, 32'h7};
  logic [31:0] a2 [4] = '{32'hC, 32'hC, 32'h4, 32'hC};
  int          ax [4] = '{0, 1, 1, 1};

  urx_top #(.RECOV(2)) u_urx_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_line_pin(line), .mod_clk_on(mod_clk_on), .cpu_sleep(cpu_sleep), .tx_empty(tx_empty),
    .tx_idle(tx_idle), .global_irq_gate(glb), .port_irq_gate(prt), .irq_n(irq_n), .wake_evt(wake_evt));
  urx_line_model #(.BIT(16)) u_urx_line_model (.core_clk(core_clk), .line(line));

  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  // Count request pulses and cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (irq_n === 1'b0) irqs++;
    if (wake_evt === 1'b1) wakes++;
    if (cyc == 40000) begin
      errors++;
      print_verdict();
    end
  end
  // One bus transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, d & m);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 1; i < 4; i++) rc(12'(4 * i), 32'hFFFFFFFF, 32'h0, "reset value");
    apb(1'b0, 12'h020, 32'h0);
    chk("refused", 32'h1, {31'h0, err});
    apb(1'b1, `URX_OFF_CTL1, 32'hFFFFFFFF);
    rc(`URX_OFF_CTL1, 32'hFFFFFFFF, 32'h1FF, "ctl1 width");
    apb(1'b1, `URX_OFF_STAT, 32'hFFFFFFFF);
    rc(`URX_OFF_STAT, 32'h1F, 32'h0, "stat write");
    $display("test registers done");
    for (int pt = 0; pt < 4; pt++) begin
      apb(1'b1, `URX_OFF_CTL1, 32'h00B | (32'(pt) << 4));
      u_urx_line_model.send(9'h05A, 1'b0, 1'b1, 2'(pt), 1'b0, 1'b0, 1'b0);
      rc(`URX_OFF_STAT, 32'h13, 32'h10, "parity good");
      rc(`URX_OFF_DATA, 32'h1FF, 32'h5A, "data good");
      u_urx_line_model.send(9'h0A5, 1'b0, 1'b1, 2'(pt), 1'b0, 1'b1, 1'b0);
      rc(`URX_OFF_STAT, 32'h3, 32'h2, "parity bad");
      rc(`URX_OFF_DATA, 32'h1FF, 32'hA5, "data kept");
      rc(`URX_OFF_STAT, 32'h3, 32'h0, "parity cleared");
    end
    $display("test parity done");
    apb(1'b1, `URX_OFF_CTL1, 32'h043);
    u_urx_line_model.send(9'h03C, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0, 1'b1);
    rc(`URX_OFF_STAT, 32'h1, 32'h1, "stop fault");
    rc(`URX_OFF_DATA, 32'h1FF, 32'h3C, "stop data");
    rc(`URX_OFF_STAT, 32'h1, 32'h0, "stop cleared");
    $display("test stop done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `URX_OFF_CTL1, a1[i]);
      apb(1'b1, `URX_OFF_CTL2, a2[i]);
      n = irqs;
      u_urx_line_model.send(aw[i], a1[i][2], 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
      chk("address irq", 32'(ax[i]), 32'(irqs - n));
      rc(`URX_OFF_DATA, 32'h1FF, 32'(aw[i]), "address data");
    end
    $display("test address done");
    apb(1'b1, `URX_OFF_CTL1, 32'h3);
    apb(1'b1, `URX_OFF_CTL2, 32'h0);
    for (int i = 0; i < 6; i++) u_urx_line_model.send(9'(8'h10 + i), 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
    rc(`URX_OFF_STAT, 32'h704, 32'h404, "overrun count");
    for (int i = 0; i < 5; i++) rc(`URX_OFF_DATA, 32'h1FF, (i < 4) ? 32'h10 + i : 32'h15, "fifo");
    $display("test overrun done");
    rc(`URX_OFF_STAT, 32'h80, 32'h80, "idle before sleep");
    cpu_sleep <= 1'b1;
    u_urx_line_model.send(9'h033, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
    rc(`URX_OFF_CTL1, 32'h1FF, 32'h3, "ctl1 in sleep");
    cpu_sleep <= 1'b0;
    rc(`URX_OFF_STAT, 32'h710, 32'h0, "paused in sleep");
    $display("test sleep done");
    apb(1'b1, `URX_OFF_CTL2, 32'h1);
    n = irqs;
    tx_idle <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("tx idle masked", 32'h0, 32'(irqs - n));
    tx_empty <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("tx empty irq", 32'h1, 32'(irqs - n));
    apb(1'b1, `URX_OFF_CTL2, 32'h2);
    tx_idle <= 1'b0;
    repeat (2) @(posedge core_clk);
    n = irqs;
    tx_idle <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("tx idle irq", 32'h1, 32'(irqs - n));
    $display("test transmit done");
    apb(1'b1, `URX_OFF_CTL2, 32'h14);
    for (int g = 2; g >= 0; g--) begin
      glb <= (g != 1);
      prt <= (g != 0);
      mod_clk_on <= 1'b0;
      n = irqs;
      k = wakes;
      u_urx_line_model.send(9'h000, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
      chk("wake", 32'h1, 32'(wakes - k));
      chk("wake irq", 32'(g == 2), 32'(irqs - n));
      mod_clk_on <= 1'b1;
      rc(`URX_OFF_STAT, 32'h710, 32'h0, "discarded");
    end
    $display("test wake done");
    print_verdict();
  end
endmodule

// ==== common/urx_regs.vh ====
/*
 * Register map, field positions, reset values and counts for the serial
 * receive error, interrupt and wake-up block.
 * Assumes a 32-bit APB bus with byte addresses and one word per register.
 */
// What this block does
// R1: Low stop bit sets stop-bit fault
// R2: Faulty word still stored; reset clears flag
// R3: Parity mismatch sets fault when parity on
// R4: Word kept on parity fault; reset clears
// R5: Software reads status before data word
// R6: Six sources share one low irq pulse
// R7: Tx sources own enables; rx pair shares
// R8: Address word requests irq when qualify set
// R9: Status flags ignore software writes
// R10: Qualify on: irq only if top bit 1
// R11: Qualify off: irq on every word that leaves the FIFO count at or above the trigger level; a parked held word raises none until a pop moves it in
// R12: Software clears parity when qualify on
// R13: Reception pauses when clock off or sleep
// R14: Sleep leaves all registers unchanged
// R15: Pin falling edge wakes when armed
// R16: Line data during recovery is discarded
// R17: Wake irq needs global and port gates
// R18: Wake irq waits for recovery cycles
// R19: Software finishes traffic before sleeping
// R20: Status read then data read clears errors
// R21: Four-word FIFO plus one held word
// R22: Even, odd, mark, space parity expected
`ifndef URX_REGS_VH
`define URX_REGS_VH
// Byte offsets
`define URX_OFF_STAT  12'h000
`define URX_OFF_CTL1  12'h004
`define URX_OFF_CTL2  12'h008
`define URX_OFF_BAUD  12'h00C
`define URX_OFF_DATA  12'h010
// Status bits
`define URX_ST_FERR   0
`define URX_ST_PERR   1
`define URX_ST_OVR    2
`define URX_ST_NOISE  3
`define URX_ST_AVAIL  4
`define URX_ST_TXE    5
`define URX_ST_TXI    6
`define URX_ST_RIDLE  7
`define URX_ST_CNT_LO 8
// Control one bits
`define URX_C1_PORT   0
`define URX_C1_RXON   1
`define URX_C1_NINE   2
`define URX_C1_PAR    3
`define URX_C1_PTYP   4
`define URX_C1_STOP2  6
`define URX_C1_TRIG   7
// Control two bits
`define URX_C2_TXEIE  0
`define URX_C2_TXIIE  1
`define URX_C2_RXIE   2
`define URX_C2_ADQ    3
`define URX_C2_WAKE   4
// Parity types
`define URX_PAR_EVEN  2'h0
`define URX_PAR_ODD   2'h1
`define URX_PAR_MARK  2'h2
`define URX_PAR_SPACE 2'h3
// Reset values
`define URX_CTL1_RST  9'h000
`define URX_CTL2_RST  5'h00
`define URX_BAUD_RST  16'h0000
// Counts
`define URX_FIFO_D    4
`define URX_RECOV     16
`endif

// ==== hdl/urx_core.v ====
/*
 * Frame receiver: start detect, data, parity and stop sampling at
 * sixteen ticks per bit.
 * Assumes rxd is already synchronised to clk.
 */
`timescale 1ns/1ps
`include "urx_regs.vh"
module urx_core (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Control
  input  wire       run,
  input  wire       clr,
  input  wire       rxd,
  input  wire [15:0] div,
  input  wire       nine,
  input  wire       par_on,
  input  wire [1:0] par_type,
  input  wire       two_stop,
  // Result
  output reg        done_r,
  output reg  [8:0] word_r,
  output reg        ferr_r,
  output reg        perr_r,
  output wire       busy
);
  localparam IDLE = 3'h0, START = 3'h1, DATA = 3'h2;
  localparam PAR = 3'h3, STOP = 3'h4, BRK = 3'h5;
  reg [2:0]  st_r;
  reg [15:0] dcnt_r;
  reg [3:0]  sub_r;
  reg [3:0]  n_r;
  reg [8:0]  sh_r;
  reg        pbit_r;
  reg        fe_r;
  wire       tick = run & (dcnt_r == div);
  wire       mid  = (sub_r == 4'hF);
  wire [8:0] wv   = nine ? sh_r : {1'b0, sh_r[8:1]};

  // Expected parity bit of a word
  function pexp;
    input [8:0] w;
    input [1:0] t;
    begin
      case (t)
        `URX_PAR_EVEN: pexp = ^w;     // [R22]
        `URX_PAR_ODD:  pexp = ~(^w);  // [R22]
        `URX_PAR_MARK: pexp = 1'b1;   // [R22]
        default:       pexp = 1'b0;   // [R22]
      endcase
    end
  endfunction

  assign busy = (st_r != IDLE);

  // Frame state machine; halts with run low
  always @(posedge clk) begin
    if (rst | clr) begin
      st_r <= IDLE;
      dcnt_r <= 16'h0000;
      sub_r <= 4'h0;
      n_r <= 4'h0;
      sh_r <= 9'h000;
      pbit_r <= 1'b0;
      fe_r <= 1'b0;
      done_r <= 1'b0;
      word_r <= 9'h000;
      ferr_r <= 1'b0;
      perr_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (run) begin // [R13]
        dcnt_r <= tick ? 16'h0000 : dcnt_r + 16'h0001;
      end
      if (tick) begin
        sub_r <= sub_r + 4'h1;
        case (st_r)
          IDLE: begin
            sub_r <= 4'h0;
            if (!rxd) st_r <= START;
          end
          START: begin
            if (sub_r == 4'h7) begin
              sub_r <= 4'h0;
              n_r <= 4'h0;
              fe_r <= 1'b0;
              st_r <= rxd ? IDLE : DATA;
            end
          end
          DATA: begin
            if (mid) begin
              sh_r <= {rxd, sh_r[8:1]};
              n_r <= n_r + 4'h1;
              if (n_r == (nine ? 4'h8 : 4'h7)) begin
                n_r <= 4'h0;
                st_r <= par_on ? PAR : STOP;
              end
            end
          end
          PAR: begin
            if (mid) begin
              pbit_r <= rxd;
              st_r <= STOP;
            end
          end
          STOP: begin
            if (mid) begin
              if (two_stop && n_r == 4'h0) begin
                n_r <= 4'h1;
                fe_r <= ~rxd; // [R1]
              end else begin
                done_r <= 1'b1; // [R2] [R4]
                word_r <= wv;
                ferr_r <= fe_r | ~rxd; // [R1]
                perr_r <= par_on & (pbit_r != pexp(wv, par_type)); // [R3]
                st_r <= rxd ? IDLE : BRK;
              end
            end
          end
          BRK: if (rxd) st_r <= IDLE; // Wait out a break
          default: st_r <= IDLE;
        endcase
      end
    end
  end
endmodule

// ==== hdl/urx_top.v ====
/*
 * Serial receive block: APB registers, four-word receive FIFO with a held
 * fifth word, error flags, shared interrupt pulse and line-pin wake-up.
 * Assumes a 20 MHz core_clk, synchronous active-high rst, transmitter
 * status levels on core_clk, and the line pin asynchronous.
 */
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "urx_regs.vh"
module urx_top #(
  parameter RECOV = `URX_RECOV
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Serial line
  input  wire        serial_line_pin,
  // Power state
  input  wire        mod_clk_on,
  input  wire        cpu_sleep,
  // Transmitter status
  input  wire        tx_empty,
  input  wire        tx_idle,
  // Interrupt controller gates
  input  wire        global_irq_gate,
  input  wire        port_irq_gate,
  // Requests
  output reg         irq_n,
  output reg         wake_evt
);
  // FIFO depth; one more word may wait in the held slot
  localparam DEPTH = `URX_FIFO_D;

  // Control registers
  reg [8:0]  ctl1_r;
  reg [4:0]  ctl2_r;
  reg [15:0] baud_r;
  wire       port_on         = ctl1_r[`URX_C1_PORT];
  wire       receiver_on     = ctl1_r[`URX_C1_RXON];
  wire       nine_bit_select = ctl1_r[`URX_C1_NINE];
  wire       parity_on       = ctl1_r[`URX_C1_PAR];
  wire [1:0] par_type        = ctl1_r[`URX_C1_PTYP+1:`URX_C1_PTYP];
  wire       two_stop        = ctl1_r[`URX_C1_STOP2];
  wire [2:0] trig_lv         = {1'b0, ctl1_r[`URX_C1_TRIG+1:`URX_C1_TRIG]} + 3'h1;
  wire       tx_empty_irq_on = ctl2_r[`URX_C2_TXEIE];
  wire       tx_idle_irq_on  = ctl2_r[`URX_C2_TXIIE];
  wire       rx_irq_on       = ctl2_r[`URX_C2_RXIE];
  wire       addr_qualify_on = ctl2_r[`URX_C2_ADQ];
  wire       pin_wake_on     = ctl2_r[`URX_C2_WAKE];

  // Line synchroniser
  reg        s1_r;
  reg        s2_r;
  reg        s3_r;
  reg        line_r;
  reg        line_prev_r;

  // FIFO and held word
  reg [8:0]  mem [0:DEPTH-1];
  reg [1:0]  rd_ptr_r;
  reg [1:0]  wr_ptr_r;
  reg [2:0]  cnt_r;
  reg [8:0]  hold_r;
  reg        hold_v_r;

  // Flags
  reg        stop_bit_fault_flag;
  reg        parity_fault_flag;
  reg        overrun_flag;
  reg        arm_r;

  // Interrupt and wake state
  reg        txe_prev_r;
  reg        txi_prev_r;
  reg        wk_busy_r;
  reg [15:0] wk_cnt_r;

  // Receiver core outputs
  wire       cd;
  wire [8:0] cword;
  wire       cferr;
  wire       cperr;
  wire       cbusy;

  // Top bit of a word marks an address
  function topbit;
    input [8:0] w;
    input       nine;
    begin
      topbit = nine ? w[8] : w[7]; // [R10]
    end
  endfunction

  // Bus decode
  wire setup    = psel & ~penable;
  wire acc      = psel & penable & pready;
  wire rd_stat  = acc & ~pwrite & (paddr == `URX_OFF_STAT);
  wire rd_data  = acc & ~pwrite & (paddr == `URX_OFF_DATA);
  wire pop      = rd_data & (cnt_r != 3'h0);
  wire err_clr  = rd_data & arm_r; // [R20]
  wire mapped   = (paddr == `URX_OFF_STAT) | (paddr == `URX_OFF_CTL1) |
                  (paddr == `URX_OFF_CTL2) | (paddr == `URX_OFF_BAUD) |
                  (paddr == `URX_OFF_DATA);

  // Receiver runs only when enabled, clocked and awake
  wire rx_en  = port_on & receiver_on;
  wire rx_run = rx_en & mod_clk_on & ~cpu_sleep; // [R13]
  wire rx_clr = ~rx_en | wk_busy_r;              // [R16]

  urx_core u_core (
    .clk      (core_clk),
    .rst      (rst),
    .run      (rx_run),
    .clr      (rx_clr),
    .rxd      (line_r),
    .div      (baud_r),
    .nine     (nine_bit_select),
    .par_on   (parity_on),
    .par_type (par_type),
    .two_stop (two_stop),
    .done_r   (cd),
    .word_r   (cword),
    .ferr_r   (cferr),
    .perr_r   (cperr),
    .busy     (cbusy)
  );

  // FIFO write selection; the held word enters first
  // A word that completes while the FIFO is full parks in the held slot,
  // giving software one more frame time to drain; a second word before a
  // pop overwrites the slot and flags an overrun, keeping the FIFO intact
  reg       wr_en;
  reg [8:0] wr_data;
  reg       hold_v_nxt;
  reg [8:0] hold_nxt;
  reg       ovr_evt;
  always @* begin
    wr_en = 1'b0;
    wr_data = cword;
    hold_v_nxt = hold_v_r;
    hold_nxt = hold_r;
    ovr_evt = 1'b0;
    if (hold_v_r) begin
      if (pop) begin
        wr_en = 1'b1;
        wr_data = hold_r;
        hold_v_nxt = cd;
        if (cd) hold_nxt = cword;
      end else if (cd) begin
        ovr_evt = 1'b1; // [R21] FIFO words kept, held word replaced
        hold_nxt = cword;
      end
    end else if (cd) begin
      if (cnt_r < DEPTH[2:0] || pop) begin // [R21]
        wr_en = 1'b1;
      end else begin
        hold_v_nxt = 1'b1; // [R21] Fifth word waits in the held slot
        hold_nxt = cword;
      end
    end
  end

  wire [2:0] cnt_nxt = cnt_r + {2'h0, wr_en} - {2'h0, pop};

  // Interrupt events
  // All sources fold into one registered pulse, so events that land in the
  // same cycle merge into a single request
  wire txe_evt  = tx_empty & ~txe_prev_r & tx_empty_irq_on; // [R7]
  wire txi_evt  = tx_idle & ~txi_prev_r & tx_idle_irq_on;   // [R7]
  wire addr_w   = wr_en & topbit(wr_data, nine_bit_select);
  wire trig_evt = wr_en & (cnt_nxt >= trig_lv) & rx_irq_on &
                  (~addr_qualify_on | addr_w);              // [R7] [R10] [R11]
  wire ovr_irq  = ovr_evt & rx_irq_on;                      // [R7]
  wire adr_evt  = addr_w & addr_qualify_on;                 // [R8]
  wire wk_done  = wk_busy_r & (wk_cnt_r == 16'h0000);
  wire wk_irq   = wk_done & global_irq_gate & port_irq_gate; // [R17] [R18]
  wire any_evt  = txe_evt | txi_evt | trig_evt | ovr_irq | adr_evt | wk_irq;

  // Wake-up arming while the module clock is off
  // Only the filtered level is watched, so a one-sample glitch cannot wake
  wire line_fall = line_prev_r & ~line_r;
  wire wk_arm    = ~mod_clk_on & port_on & receiver_on & rx_irq_on & pin_wake_on;
  wire wk_start  = line_fall & wk_arm & ~wk_busy_r; // [R15]

  // Three-stage line synchroniser; level moves when stages two and three agree
  // The first stage may go metastable, so only the second stage reads it
  always @(posedge core_clk) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      line_r <= 1'b1;
      line_prev_r <= 1'b1;
    end else begin
      s1_r <= serial_line_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) line_r <= s3_r;
      line_prev_r <= line_r;
    end
  end

  // FIFO storage
  always @(posedge core_clk) begin
    if (wr_en) mem[wr_ptr_r] <= wr_data; // [R2] [R4]
  end

  // FIFO pointers and held word; sleep alone changes nothing here
  always @(posedge core_clk) begin
    if (rst) begin
      rd_ptr_r <= 2'h0;
      wr_ptr_r <= 2'h0;
      cnt_r <= 3'h0;
      hold_r <= 9'h000;
      hold_v_r <= 1'b0;
    end else if (~rx_en) begin
      rd_ptr_r <= 2'h0; // Turning the receiver off flushes it
      wr_ptr_r <= 2'h0;
      cnt_r <= 3'h0;
      hold_v_r <= 1'b0;
    end else begin
      if (wr_en) wr_ptr_r <= wr_ptr_r + 2'h1;
      if (pop) rd_ptr_r <= rd_ptr_r + 2'h1;
      cnt_r <= cnt_nxt;
      hold_r <= hold_nxt;
      hold_v_r <= hold_v_nxt;
    end
  end

  // Error flags: a new fault wins over a clear in the same cycle
  // The arm bit remembers a status read; any data read disarms it, so a
  // data read alone never clears a fault that software has not yet seen
  always @(posedge core_clk) begin
    if (rst) begin
      stop_bit_fault_flag <= 1'b0; // [R2]
      parity_fault_flag <= 1'b0;   // [R4]
      overrun_flag <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      stop_bit_fault_flag <= (cd & cferr) | (stop_bit_fault_flag & ~err_clr); // [R1] [R20]
      parity_fault_flag <= (cd & cperr) | (parity_fault_flag & ~err_clr);     // [R3] [R20]
      overrun_flag <= ovr_evt | (overrun_flag & ~err_clr);                    // [R20]
      if (rd_stat) arm_r <= 1'b1;
      else if (rd_data) arm_r <= 1'b0;
    end
  end

  // Control registers; status holds no writable bits
  // Nothing here looks at sleep, so idle and sleep leave every setting intact
  always @(posedge core_clk) begin
    if (rst) begin
      ctl1_r <= `URX_CTL1_RST;
      ctl2_r <= `URX_CTL2_RST;
      baud_r <= `URX_BAUD_RST;
    end else if (acc & pwrite) begin // [R9] [R14]
      case (paddr)
        `URX_OFF_CTL1: ctl1_r <= pwdata[8:0];
        `URX_OFF_CTL2: ctl2_r <= pwdata[4:0];
        `URX_OFF_BAUD: baud_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data selection
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `URX_OFF_STAT: begin
        rd_mux[`URX_ST_FERR] = stop_bit_fault_flag;
        rd_mux[`URX_ST_PERR] = parity_fault_flag;
        rd_mux[`URX_ST_OVR] = overrun_flag;
        rd_mux[`URX_ST_AVAIL] = (cnt_r != 3'h0);
        rd_mux[`URX_ST_TXE] = tx_empty;
        rd_mux[`URX_ST_TXI] = tx_idle;
        rd_mux[`URX_ST_RIDLE] = ~cbusy;
        rd_mux[`URX_ST_CNT_LO+2:`URX_ST_CNT_LO] = cnt_r;
      end
      `URX_OFF_CTL1: rd_mux[8:0] = ctl1_r;
      `URX_OFF_CTL2: rd_mux[4:0] = ctl2_r;
      `URX_OFF_BAUD: rd_mux[15:0] = baud_r;
      `URX_OFF_DATA: rd_mux[8:0] = mem[rd_ptr_r];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // APB answer: ready in the first access cycle, data caught at setup
  // Capturing at setup keeps the pop in the access cycle from changing
  // the word this same transfer returns
  always @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup & ~pwrite) prdata <= rd_mux;
    end
  end

  // Transmitter edge history
  always @(posedge core_clk) begin
    if (rst) begin
      txe_prev_r <= 1'b0;
      txi_prev_r <= 1'b0;
    end else begin
      txe_prev_r <= tx_empty;
      txi_prev_r <= tx_idle;
    end
  end

  // Wake-up recovery; receiver is held clear until it ends
  // The request waits for the count to run out so the core is awake to serve it
  always @(posedge core_clk) begin
    if (rst) begin
      wk_busy_r <= 1'b0;
      wk_cnt_r <= 16'h0000;
      wake_evt <= 1'b0;
    end else begin
      wake_evt <= wk_start; // [R15] [R17]
      if (wk_start) begin
        wk_busy_r <= 1'b1;
        wk_cnt_r <= RECOV[15:0] - 16'h0001; // [R18]
      end else if (wk_busy_r) begin
        if (wk_done) wk_busy_r <= 1'b0;
        else wk_cnt_r <= wk_cnt_r - 16'h0001;
      end
    end
  end

  // Shared low interrupt pulse
  always @(posedge core_clk) begin
    if (rst) irq_n <= 1'b1;
    else irq_n <= ~any_evt; // [R6]
  end
endmodule
